// *** shared/wss_pkg.sv ***
/*
  Constants, register map and types of the waveform setpoint sequencer.
  Assumes a 40 MHz APB clock and 16-bit setpoint codes on the regulation side.
*/
package wss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_AMP = 8'h08;
  localparam logic [7:0] A_OFS = 8'h0c;
  localparam logic [7:0] A_PH1 = 8'h10;
  localparam logic [7:0] A_PH2 = 8'h14;
  localparam logic [7:0] A_PH3 = 8'h18;
  localparam logic [7:0] A_PH4 = 8'h1c;
  localparam logic [7:0] A_CYC = 8'h20;
  localparam logic [7:0] A_PAUSE = 8'h24;
  localparam logic [7:0] A_SV = 8'h28;
  localparam logic [7:0] A_SI = 8'h2c;
  localparam logic [7:0] A_SP = 8'h30;
  localparam logic [7:0] A_BLK = 8'h34;
  localparam logic [7:0] A_PIDX = 8'h38;
  localparam logic [7:0] A_PAMP = 8'h3c;
  localparam logic [7:0] A_PDC = 8'h40;
  localparam logic [7:0] A_PFRQ = 8'h44;
  localparam logic [7:0] A_PANG = 8'h48;
  localparam logic [7:0] A_PTIM = 8'h4c;
  localparam logic [7:0] A_PCMT = 8'h50;
  // Field positions
  localparam int CT_TGT = 2;
  localparam int CT_START = 3;
  localparam int CT_STOP = 4;
  localparam int CT_OFF = 5;
  localparam int ST_ON = 0;
  localparam int ST_RUN = 1;
  localparam int ST_PAU = 2;
  localparam int ST_DONE = 3;
  localparam int ST_ERR = 4;
  localparam int ST_ALM = 5;
  localparam int HI = 16;
  localparam int BLK_LAST = 8;

  // ----------------------------------------------------------------
  // Limits and timing
  // ----------------------------------------------------------------
  localparam int MAX_PT = 99;
  localparam logic [9:0] MAX_CYC = 10'd999;
  localparam logic [6:0] CRANK_LAST = 7'd4;
  localparam logic [13:0] FMAX = 14'd10000;
  localparam logic [8:0] ANG_MAX = 9'd359;
  localparam int CLK_PS = 25000;
  localparam int TICK_PS = 100000000;
  localparam int TICK_CYC_DEF = TICK_PS / CLK_PS;
  localparam logic [28:0] DUR_MIN = 29'd1;
  localparam logic [28:0] DUR_MAX = 29'd360000000;
  localparam logic [63:0] DF_SCALE = 64'd100000;
  localparam logic [63:0] DF_MIN_X10 = 64'd93;
  localparam logic [63:0] AMP_TICK_MAX = 64'd1000000;
  localparam logic [31:0] PH_PER_HZ = 32'd107;
  localparam logic [31:0] PH_PER_DEG = 32'd11930465;
  localparam logic [6:0] RST_FIRST = 7'd1;
  localparam logic [9:0] RST_CYC = 10'd1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_RECT, M_TRAP, M_CRANK, M_ARB} wss_mode_t;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_PAUSE} wss_fsm_t;
  typedef struct packed {
    logic signed [15:0] sine_amp_begin;
    logic signed [15:0] sine_amp_finish;
    logic signed [15:0] ramp_level_begin;
    logic signed [15:0] ramp_level_finish;
    logic [13:0] f_b;
    logic [13:0] f_f;
    logic [8:0] ang;
    logic [28:0] dur;
  } wss_pt_t;

endpackage : wss_pkg

// *** design/wss_top.sv ***
/*
  Waveform setpoint sequencer: APB register file, rectangle, trapezoid,
  cranking curve (voltage only) and arbitrary point sequencer driving voltage or current
  setpoints, with a static power setpoint. Assumes one clock and a raw asynchronous alarm pin.
*/
module wss_top
#(
  parameter logic signed [15:0] RATED = 16'sh7fff,
  parameter int TICK_CYC = wss_pkg::TICK_CYC_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alarm_pin,
  output logic [15:0] set_v,
  output logic [15:0] set_i,
  output logic [15:0] set_p,
  output logic input_on,
  output logic fg_done
);
  import wss_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    wss_mode_t mode;
    logic tgt;
    logic on;
    wss_fsm_t st;
    logic [6:0] part;
    logic [28:0] el;
    logic [9:0] cyc_left;
    logic signed [15:0] amp;
    logic signed [15:0] ofs;
    logic [3:0][28:0] tph;
    logic [9:0] cyc;
    logic [28:0] pause;
    logic [15:0] sv;
    logic [15:0] si;
    logic [15:0] sp;
    logic [6:0] first;
    logic [6:0] last;
    logic [6:0] idx;
    wss_pt_t stg;
    wss_pt_t [MAX_PT-1:0] pts;
    logic err;
    logic alarm;
    logic done;
    logic tick;
    logic [11:0] tcnt;
    logic a1;
    logic a2;
    logic a3;
    logic alarm_q;
    logic [31:0] phase;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] set_v;
    logic [15:0] set_i;
    logic [15:0] set_p;
  } wss_state_t;

  wss_state_t r_r;
  wss_state_t r_nxt;
  logic wr;
  logic go;
  logic cur;
  logic last_p;
  logic [6:0] first_p;
  logic [28:0] dur;
  logic signed [15:0] hi_lvl;
  logic signed [15:0] lvl;
  logic signed [15:0] am;
  logic signed [15:0] fnow;
  wss_pt_t cp;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Linear interpolation a..b over e of d ticks
  function automatic logic signed [15:0] lerp(input logic signed [15:0] a, input logic signed [15:0] b,
                                              input logic [28:0] e, input logic [28:0] d);
    logic signed [63:0] p;
    p = (64'(b) - 64'(a)) * $signed({35'd0, e});
    if (d != '0)
      p = p / $signed({35'd0, d});
    return (d == '0) ? a : 16'(64'(a) + p);
  endfunction : lerp

  // Parabolic sine; within a few percent, cheap and divider free
  function automatic logic signed [15:0] sin16(input logic [9:0] ph);
    logic [16:0] y;
    logic [15:0] m;
    y = 17'({8'd0, ph[8:0]} * (17'd512 - {8'd0, ph[8:0]}));
    m = 16'((y >> 1) - {16'd0, y[16]});
    return ph[9] ? -$signed(m) : $signed(m);
  endfunction : sin16

  function automatic logic dur_ok(input logic [28:0] d);
    return d >= DUR_MIN && d <= DUR_MAX;
  endfunction : dur_ok

  function automatic logic amp_ok(input logic signed [15:0] a, input logic c);
    return c ? (a <= (RATED >>> 1) && a >= -(RATED >>> 1)) : (a >= 0 && a <= (RATED >>> 1));
  endfunction : amp_ok

  function automatic logic [63:0] absd(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    return 64'(d[16] ? -d : d);
  endfunction : absd

  // Point acceptance check
  function automatic logic pt_ok(input wss_pt_t p, input logic c);
    logic [63:0] df;
    logic [63:0] da;
    logic ok;
    df = 64'(p.f_b > p.f_f ? p.f_b - p.f_f : p.f_f - p.f_b);
    da = absd(p.sine_amp_begin, p.sine_amp_finish);
    ok = dur_ok(p.dur) && p.ang <= ANG_MAX;
    ok = ok && p.f_b <= FMAX && p.f_f <= FMAX;
    ok = ok && amp_ok(p.sine_amp_begin, c) && amp_ok(p.sine_amp_finish, c);
    if (df != '0 && df * DF_SCALE < DF_MIN_X10 * 64'(p.dur))
      ok = 1'b0;
    if (da != '0 && da * AMP_TICK_MAX < 64'(p.dur))
      ok = 1'b0;
    return ok;
  endfunction : pt_ok

  function automatic logic is_map(input logic [7:0] a);
    return a <= A_PCMT && a[1:0] == 2'b00;
  endfunction : is_map

  // First segment of a run; only the point block starts away from zero
  function automatic logic [6:0] start_part(input wss_mode_t m, input logic [6:0] f);
    return (m == M_ARB) ? f - RST_FIRST : 7'd0;
  endfunction : start_part

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_nxt = r_r;
    go = 1'b0;
    // Alarm pin: three stages, accepted once stages two and three agree
    r_nxt.a1 = alarm_pin;
    r_nxt.a2 = r_r.a1;
    r_nxt.a3 = r_r.a2;
    if (r_r.a2 == r_r.a3)
      r_nxt.alarm_q = r_r.a3;
    // Common time base
    r_nxt.tick = (r_r.tcnt == 12'(TICK_CYC - 1));
    r_nxt.tcnt = r_nxt.tick ? '0 : r_r.tcnt + 12'd1;

    // Current segment figures
    cur = r_r.tgt && r_r.mode != M_CRANK;
    cp = r_r.pts[r_r.part];
    hi_lvl = 16'(r_r.ofs + r_r.amp);
    first_p = start_part(r_r.mode, r_r.first);
    fnow = lerp($signed({2'b00, cp.f_b}), $signed({2'b00, cp.f_f}), r_r.el, cp.dur);
    am = lerp(cp.sine_amp_begin, cp.sine_amp_finish, r_r.el, cp.dur);
    dur = cp.dur;
    last_p = 1'b0;
    lvl = r_r.ofs;
    unique case (r_r.mode)
      M_RECT:
      begin
        dur = r_r.tph[1'(r_r.part)];
        last_p = 1'(r_r.part);
        lvl = last_p ? r_r.ofs : hi_lvl;
      end
      M_TRAP:
      begin
        dur = r_r.tph[2'(r_r.part)];
        last_p = (2'(r_r.part) == 2'd3);
        unique case (2'(r_r.part))
          2'd0: lvl = lerp(r_r.ofs, hi_lvl, r_r.el, dur);
          2'd1: lvl = hi_lvl;
          2'd2: lvl = lerp(hi_lvl, r_r.ofs, r_r.el, dur);
          2'd3: lvl = r_r.ofs;
        endcase
      end
      M_CRANK:
      begin
        last_p = (r_r.part == CRANK_LAST);
        lvl = lerp(cp.ramp_level_begin, cp.ramp_level_finish, r_r.el, dur);
      end
      M_ARB:
      begin
        last_p = (r_r.part == r_r.last - RST_FIRST);
        lvl = lerp(cp.ramp_level_begin, cp.ramp_level_finish, r_r.el, dur);
        if (cp.f_b != '0 || cp.f_f != '0)
          lvl = 16'(lvl + 16'((32'(am) * 32'(sin16(r_r.phase[31:22]))) >>> 15));
      end
    endcase
    // Swept sine phase runs every clock
    // Part-select keeps frequencies above 8191 Hz from sign-extending
    r_nxt.phase = r_r.phase + 32'(fnow[13:0]) * PH_PER_HZ;

    // APB: one wait cycle so read data leaves a flip-flop
    r_nxt.pready = psel && penable && !r_r.pready;
    r_nxt.pslverr = r_nxt.pready && !is_map(paddr);
    wr = psel && penable && r_r.pready && pwrite && !r_r.pslverr;
    unique case (paddr)
      A_CTRL: r_nxt.prdata = 32'({r_r.tgt, r_r.mode});
      A_STAT: r_nxt.prdata = 32'({r_r.alarm, r_r.err, r_r.done, r_r.st == S_PAUSE, r_r.st == S_RUN, r_r.on});
      A_AMP: r_nxt.prdata = 32'(r_r.amp);
      A_OFS: r_nxt.prdata = 32'(r_r.ofs);
      A_PH1, A_PH2, A_PH3, A_PH4: r_nxt.prdata = 32'(r_r.tph[2'((paddr - A_PH1) >> 2)]);
      A_CYC: r_nxt.prdata = 32'(r_r.cyc);
      A_PAUSE: r_nxt.prdata = 32'(r_r.pause);
      A_SV: r_nxt.prdata = 32'(r_r.sv);
      A_SI: r_nxt.prdata = 32'(r_r.si);
      A_SP: r_nxt.prdata = 32'(r_r.sp);
      A_BLK: r_nxt.prdata = 32'({r_r.last, 1'b0, r_r.first});
      A_PIDX: r_nxt.prdata = 32'(r_r.idx);
      A_PAMP: r_nxt.prdata = {r_r.stg.sine_amp_finish, r_r.stg.sine_amp_begin};
      A_PDC: r_nxt.prdata = {r_r.stg.ramp_level_finish, r_r.stg.ramp_level_begin};
      A_PFRQ: r_nxt.prdata = {2'b00, r_r.stg.f_f, 2'b00, r_r.stg.f_b};
      A_PANG: r_nxt.prdata = 32'(r_r.stg.ang);
      A_PTIM: r_nxt.prdata = 32'(r_r.stg.dur);
      default: r_nxt.prdata = '0;
    endcase

    // Register writes; set-up is frozen while the input is on
    if (wr)
    begin
      unique case (paddr)
        A_CTRL:
        begin
          if (!r_r.on)
          begin
            r_nxt.mode = wss_mode_t'(pwdata[1:0]);
            r_nxt.tgt = pwdata[CT_TGT];
          end
          if (pwdata[CT_START] && !r_r.alarm_q)
          begin
            go = 1'b1;
            r_nxt.st = S_RUN;
            r_nxt.on = 1'b1;
            r_nxt.el = '0;
            // Mode written in this same transfer decides the first segment
            r_nxt.part = start_part(r_nxt.mode, r_r.first);
            r_nxt.cyc_left = r_r.cyc;
            r_nxt.done = 1'b0;
            r_nxt.phase = 32'(r_r.pts[r_nxt.part].ang) * PH_PER_DEG;
          end
          if (pwdata[CT_STOP])
            r_nxt.st = S_IDLE;
          if (pwdata[CT_OFF])
          begin
            r_nxt.st = S_IDLE;
            r_nxt.on = 1'b0;
          end
        end
        A_STAT:
        begin
          r_nxt.done = r_r.done && !pwdata[ST_DONE];
          r_nxt.err = r_r.err && !pwdata[ST_ERR];
          r_nxt.alarm = r_r.alarm && !pwdata[ST_ALM];
        end
        A_SV: r_nxt.sv = pwdata[15:0];
        A_SI: r_nxt.si = pwdata[15:0];
        A_SP: r_nxt.sp = pwdata[15:0];
        default:
        begin
          if (!r_r.on)
          begin
            unique case (paddr)
              A_AMP: r_nxt.amp = pwdata[15:0];
              A_OFS: r_nxt.ofs = pwdata[15:0];
              A_PH1, A_PH2, A_PH3, A_PH4:
                if (dur_ok(pwdata[28:0]))
                  r_nxt.tph[2'((paddr - A_PH1) >> 2)] = pwdata[28:0];
                else
                  r_nxt.err = 1'b1;
              A_CYC:
                if (pwdata[9:0] <= MAX_CYC)
                  r_nxt.cyc = pwdata[9:0];
                else
                  r_nxt.err = 1'b1;
              A_PAUSE:
                if (dur_ok(pwdata[28:0]))
                  r_nxt.pause = pwdata[28:0];
                else
                  r_nxt.err = 1'b1;
              A_BLK:
                if (pwdata[6:0] >= RST_FIRST && pwdata[6:0] <= pwdata[BLK_LAST+:7]
                    && pwdata[BLK_LAST+:7] <= 7'(MAX_PT))
                begin
                  r_nxt.first = pwdata[6:0];
                  r_nxt.last = pwdata[BLK_LAST+:7];
                end
                else
                  r_nxt.err = 1'b1;
              A_PIDX:
                if (pwdata[6:0] >= RST_FIRST && pwdata[6:0] <= 7'(MAX_PT))
                  r_nxt.idx = pwdata[6:0];
                else
                  r_nxt.err = 1'b1;
              A_PAMP: {r_nxt.stg.sine_amp_finish, r_nxt.stg.sine_amp_begin} = pwdata;
              A_PDC: {r_nxt.stg.ramp_level_finish, r_nxt.stg.ramp_level_begin} = pwdata;
              A_PFRQ:
              begin
                r_nxt.stg.f_b = pwdata[13:0];
                r_nxt.stg.f_f = pwdata[HI+:14];
              end
              A_PANG: r_nxt.stg.ang = pwdata[8:0];
              A_PTIM: r_nxt.stg.dur = pwdata[28:0];
              A_PCMT:
                if (pt_ok(r_r.stg, r_r.tgt))
                  r_nxt.pts[r_r.idx - RST_FIRST] = r_r.stg;
                else
                  r_nxt.err = 1'b1;
              default: ;
            endcase
          end
        end
      endcase
    end

    // Sequencing on the tick; hardware sets after software clears
    if (r_r.st != S_IDLE && r_nxt.st != S_IDLE && !go && r_r.tick)
    begin
      r_nxt.el = r_r.el + 29'd1;
      if (r_r.st == S_PAUSE)
      begin
        if (r_nxt.el >= r_r.pause)
        begin
          r_nxt.st = S_RUN;
          r_nxt.el = '0;
        end
      end
      else if (r_nxt.el >= dur)
      begin
        r_nxt.el = '0;
        if (!last_p)
          r_nxt.part = r_r.part + 7'd1;
        else if (r_r.mode inside {M_CRANK, M_ARB} && r_r.cyc != '0 && r_r.cyc_left <= RST_CYC)
        begin
          r_nxt.st = S_IDLE;
          r_nxt.done = 1'b1;
        end
        else
        begin
          r_nxt.part = first_p;
          if (r_r.cyc != '0)
            r_nxt.cyc_left = r_r.cyc_left - 10'd1;
          if (r_r.mode == M_CRANK)
            r_nxt.st = S_PAUSE;
        end
        r_nxt.phase = 32'(r_r.pts[r_nxt.part].ang) * PH_PER_DEG;
      end
    end

    // Alarm wins over everything
    if (r_r.alarm_q)
    begin
      r_nxt.st = S_IDLE;
      r_nxt.on = 1'b0;
      r_nxt.alarm = 1'b1;
    end

    // Setpoints; the non-driven quantities keep their static limits
    r_nxt.set_v = (r_r.st == S_RUN && !cur) ? 16'(lvl) : r_r.sv;
    r_nxt.set_i = (r_r.st == S_RUN && cur) ? 16'(lvl) : r_r.si;
    r_nxt.set_p = r_r.sp;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_r <= '0;
      r_r.first <= RST_FIRST;
      r_r.last <= 7'(MAX_PT);
      r_r.idx <= RST_FIRST;
      r_r.cyc <= RST_CYC;
      r_r.tph <= {4{DUR_MIN}};
      r_r.pause <= DUR_MIN;
    end
    else
      r_r <= r_nxt;
  end

  assign prdata = r_r.prdata;
  assign pready = r_r.pready;
  assign pslverr = r_r.pslverr;
  assign set_v = r_r.set_v;
  assign set_i = r_r.set_i;
  assign set_p = r_r.set_p;
  assign input_on = r_r.on;
  assign fg_done = r_r.done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alarm_stop;
    $rose(r_r.alarm_q) |=> !input_on && r_r.st == S_IDLE && r_r.alarm;
  endproperty
  a_alarm_stop: assert property (p_alarm_stop) else $error("alarm did not stop");

  property p_cfg_lock;
    r_r.on && wr && paddr == A_AMP |=> $stable(r_r.amp);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config changed while on");

  property p_crank_v;
    r_r.st == S_RUN && r_r.mode == M_CRANK |=> set_i == $past(r_r.si);
  endproperty
  a_crank_v: assert property (p_crank_v) else $error("cranking touched current");

  property p_limits;
    r_r.st == S_RUN && r_r.tgt && r_r.mode != M_CRANK |=> set_v == $past(r_r.sv) && set_p == $past(r_r.sp);
  endproperty
  a_limits: assert property (p_limits) else $error("static limit lost");

  property p_rect_high;
    r_r.st == S_RUN && r_r.mode == M_RECT && r_r.part == '0 && !r_r.tgt |=> set_v == $past(16'(r_r.ofs + r_r.amp));
  endproperty
  a_rect_high: assert property (p_rect_high) else $error("rectangle high wrong");

  property p_done;
    $rose(r_r.done) |-> r_r.st == S_IDLE ##1 set_v == $past(r_r.sv);
  endproperty
  a_done: assert property (p_done) else $error("completion not static");

  property p_infinite;
    r_r.cyc == '0 && r_r.st != S_IDLE && !wr |=> !$rose(r_r.done);
  endproperty
  a_infinite: assert property (p_infinite) else $error("infinite run ended");

  property p_block;
    r_r.first >= RST_FIRST && r_r.first <= r_r.last && r_r.last <= 7'(MAX_PT);
  endproperty
  a_block: assert property (p_block) else $error("bad point block");

  property p_tick;
    r_r.tick |-> r_r.tcnt == '0 && $past(r_r.tcnt) == 12'(TICK_CYC - 1);
  endproperty
  a_tick: assert property (p_tick) else $error("tick too frequent");

  property p_commit_err;
    wr && paddr == A_PCMT && !r_r.on && !pt_ok(r_r.stg, r_r.tgt) |=> r_r.err;
  endproperty
  a_commit_err: assert property (p_commit_err) else $error("bad point accepted");

endmodule : wss_top

// *** sim/wss_reg_model.sv ***
/*
  Regulation stage model that sits behind the voltage setpoint output.
  Assumes one clock, an active-low asynchronous reset and a trip command from the bench.
*/
module wss_reg_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] set_v,
  input wire logic input_on,
  input wire logic trip,
  output logic alarm_pin,
  output logic [15:0] applied
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stage state
  // ----------------------------------------------------------------
  logic [15:0] applied_r;

  // Level the stage really regulates to, for the bench to watch
  assign applied = applied_r;

  // Stage follows the setpoint only while the input is on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied_r <= 16'h0000;
      alarm_pin <= 1'b0;
    end
    else
    begin
      applied_r <= input_on ? set_v : 16'h0000;
      alarm_pin <= trip; // Protection trip as a plain level
    end
  end
endmodule : wss_reg_model

// *** sim/testbench.sv ***
/*
  Self-checking bench: APB register access, rectangle timing, refusals and alarm.
  Assumes the sequencer built with a 4-clock tick to keep runs short.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wss_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TK = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, trip = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, alarm_pin, input_on, fg_done, er;
  logic [15:0] set_v, set_i, set_p, applied;
  int miscompares = 0, n_tests = 0, n;
  logic [7:0] bad_a [4] = '{A_PH1, A_CYC, A_BLK, A_PIDX};
  logic [31:0] bad_d [4] = '{32'h0, 32'h3e8, 32'h0305, 32'h64};

  wss_top #(.TICK_CYC(TK)) u_wss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_pin(alarm_pin), .set_v(set_v), .set_i(set_i), .set_p(set_p), .input_on(input_on),
    .fg_done(fg_done));
  wss_reg_model u_wss_reg_model (.pclk(pclk), .presetn(presetn), .set_v(set_v), .input_on(input_on),
    .trip(trip), .alarm_pin(alarm_pin), .applied(applied));

  // Free-running 40 MHz clock
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("mismatches %0d of %0d checks", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  // A wait that ran out counts once and ends the run
  task give_up;
    miscompares++;
    summarize();
  endtask : give_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; waits for pready, never assumes a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
      give_up();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Wait for a level on set_v, then count how long it is held
  task hold(input logic [15:0] v, input int exp);
    n = 0;
    while (set_v !== v && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
      give_up();
    n = 0;
    while (set_v === v && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
      give_up();
    if (exp >= 0)
      chk(32'(n), 32'(exp));
  endtask : hold

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_STAT, 0);
    chk(rd, 32'h0);
    apb(0, 8'h54, 0);
    chk({31'h0, er}, 32'h1);
    // Out-of-range values each raise the error flag, then it is cleared
    for (int k = 0; k < 4; k++)
    begin
      apb(1, bad_a[k], bad_d[k]);
      apb(0, A_STAT, 0);
      chk(rd & 32'h10, 32'h10);
      apb(1, A_STAT, 32'h38);
    end
    // Sweep of 10 Hz over 5 s is too slow and must be refused
    apb(1, A_PIDX, 32'h1);
    apb(1, A_PFRQ, 32'h000b_0001);
    apb(1, A_PTIM, 32'd50000);
    apb(1, A_PCMT, 32'h0);
    apb(0, A_STAT, 0);
    chk(rd & 32'h10, 32'h10);
    apb(1, A_STAT, 32'h38);
    // Rectangle on voltage: foot 0x40, step 0x100, two and three ticks
    apb(1, A_AMP, 32'h100);
    apb(1, A_OFS, 32'h40);
    apb(1, A_PH1, 32'h2);
    apb(1, A_PH2, 32'h3);
    apb(1, A_SI, 32'h55);
    apb(1, A_SP, 32'h66);
    apb(1, A_CTRL, 32'h08);
    hold(16'h0140, -1);
    hold(16'h0040, 3 * TK);
    hold(16'h0140, 2 * TK);
    chk({16'h0, set_v}, 32'h40);
    chk({set_i, set_p}, 32'h0055_0066);
    // Mode change while the input is on is ignored
    apb(1, A_CTRL, 32'h01);
    apb(0, A_CTRL, 0);
    chk(rd & 32'h7, 32'h0);
    // Trapezoid: one mid-rise tick, top plus fall start, then base plus rise start
    apb(1, A_CTRL, 32'h20);
    apb(1, A_CTRL, 32'h09);
    hold(16'h00c0, TK);
    hold(16'h0140, 4 * TK);
    hold(16'h0040, 2 * TK);
    // Cranking curve: five flat points of k * 0x100, two ticks each, one pass
    apb(1, A_CTRL, 32'h20);
    apb(1, A_PFRQ, 32'h0);
    apb(1, A_PTIM, 32'h2);
    for (int k = 1; k <= 5; k++)
    begin
      apb(1, A_PIDX, 32'(k));
      apb(1, A_PDC, {2{16'(k * 256)}});
      apb(1, A_PCMT, 32'h0);
    end
    apb(1, A_CYC, 32'h1);
    apb(1, A_SV, 32'h11);
    apb(1, A_CTRL, 32'h0e);
    hold(16'h0100, -1);
    for (int k = 2; k <= 5; k++)
      hold(16'(k * 256), 2 * TK);
    chk({set_i, set_v}, 32'h0055_0011);
    chk({31'h0, fg_done}, 32'h1);
    apb(0, A_STAT, 0);
    chk(rd & 32'he, 32'h8);
    // Protection trip switches the input off within a bounded time
    trip <= 1'b1;
    repeat (6) @(posedge pclk);
    trip <= 1'b0;
    n = 0;
    while (input_on !== 1'b0 && n < 12)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 12)
      give_up();
    chk({31'h0, input_on}, 32'h0);
    apb(0, A_STAT, 0);
    chk(rd & 32'h23, 32'h20);
    chk({16'h0, applied}, 32'h0);
    summarize();
  end
endmodule : testbench
